// >>> rtl/eq_search_pkg.sv
// constants and types for the adaptive equalizer gain search controller
// assumes one core clock at 40 MHz and byte-wide register access
package eq_search_pkg;

   // ---------------------------------------------------------------
   // structure
   // ---------------------------------------------------------------
   localparam int NUM_PORTS = 2;
   localparam int GAIN_W = 4;
   localparam int CNT_W = 24;
   localparam int DWELL_CODE_W = 3;
   localparam logic [GAIN_W-1:0] GAIN_MIN = 4'h0;
   localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hF;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTL_A = 8'h35;
   localparam logic [7:0] ADDR_STATUS = 8'h3B;
   localparam logic [7:0] ADDR_CTL_B = 8'h45;
   localparam int CTLA_RESTART_BIT = 0;
   localparam int CTLA_APPLY_BIT = 1;
   localparam int CTLA_OVR_BIT = 2;
   localparam logic [7:0] CTLA_MASK = 8'h06;
   localparam logic [7:0] CTLA_RESET = 8'h00;
   localparam int CTLB_FLOOR_LSB = 0;
   localparam int CTLB_DWELL_LSB = 5;
   localparam logic [7:0] CTLB_MASK = 8'hEF;
   localparam logic [7:0] CTLB_RESET = 8'h60;
   localparam int STAT_P1_LSB = 4;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int DWELL_DEFAULT_CODE = 3;
   localparam int DWELL_DEFAULT_NS = 2620000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int DWELL_DEFAULT_CYC = DWELL_DEFAULT_NS / CLK_PERIOD_NS;

   typedef enum logic {ST_SEARCH, ST_HOLD} search_state_t;

endpackage : eq_search_pkg

// >>> rtl/lock_sync.sv
// two-stage synchronizer for the analog recovery lock level
// assumes the lock input is asynchronous to CLOCK
`timescale 1ns/1ps
module lock_sync (
   input wire logic CLOCK, // core clock
   input wire logic RST, // async reset, active high
   input wire logic LOCK_ASYNC, // raw lock level
   output logic LOCK_SYNC // lock level in core domain
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   // first stage feeds only the second stage
   always_comb begin
      meta_d = LOCK_ASYNC;
      sync_d = meta_q;
   end

   // registers only
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign LOCK_SYNC = sync_q;

endmodule : lock_sync

// >>> rtl/eq_search_ctrl.sv
// adaptive equalizer gain search controller, one search per receive port
// assumes CLOCK at 40 MHz, register writes as one-cycle strobes,
// and lock levels from the analog recovery circuit on any timing
`timescale 1ns/1ps
module eq_search_ctrl #(
   parameter int DWELL_CYC = eq_search_pkg::DWELL_DEFAULT_CYC // cycles of the default dwell
) (
   input wire logic CLOCK, // core clock, 40 MHz
   input wire logic RST, // async reset, active high
   input wire logic SOFT_RST, // soft reset pulse, active high
   input wire logic [7:0] REG_ADDR, // register address
   input wire logic [7:0] REG_WDATA, // register write data
   input wire logic REG_WR, // register write strobe
   output logic [7:0] REG_RDATA, // registered read data
   input wire logic [eq_search_pkg::NUM_PORTS-1:0] CDR_LOCK, // raw lock per port
   output logic [eq_search_pkg::GAIN_W-1:0] EQ_GAIN_P0, // gain to port 0
   output logic [eq_search_pkg::GAIN_W-1:0] EQ_GAIN_P1, // gain to port 1
   output logic [eq_search_pkg::NUM_PORTS-1:0] EQ_HOLD // gain held on lock
);
   import eq_search_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // reload value so the dwell lasts the coded number of cycles
   function automatic logic [CNT_W-1:0] dwell_reload(input logic [DWELL_CODE_W-1:0] code);
      logic [31:0] t;
      t = (32'(DWELL_CYC) << code) >> DWELL_DEFAULT_CODE;
      if (t == 32'h0000_0000) begin
         t = 32'h0000_0001;
      end
      return CNT_W'(t - 32'h0000_0001);
   endfunction : dwell_reload

   // next gain upward, wrapping to the start at the fixed top
   function automatic logic [GAIN_W-1:0] next_gain(input logic [GAIN_W-1:0] g,
                                                  input logic [GAIN_W-1:0] start);
      if (g == GAIN_MAX || g < start) begin
         return start;
      end
      return g + 4'h1;
   endfunction : next_gain

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ctla_q;
   logic [7:0] ctla_d;
   logic [7:0] ctlb_q;
   logic [7:0] ctlb_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic restart_evt;
   logic floor_on;
   logic [GAIN_W-1:0] start_gain;
   logic [DWELL_CODE_W-1:0] dwell_code;
   logic [CNT_W-1:0] reload;

   search_state_t state_q [NUM_PORTS];
   search_state_t state_d [NUM_PORTS];
   logic [GAIN_W-1:0] gain_q [NUM_PORTS];
   logic [GAIN_W-1:0] gain_d [NUM_PORTS];
   logic [CNT_W-1:0] cnt_q [NUM_PORTS];
   logic [CNT_W-1:0] cnt_d [NUM_PORTS];
   logic [NUM_PORTS-1:0] lock_s;

   // decoded controls shared by every port
   always_comb begin
      restart_evt = SOFT_RST |
                    (REG_WR && REG_ADDR == ADDR_CTL_A && REG_WDATA[CTLA_RESTART_BIT]);
      floor_on = ctla_q[CTLA_OVR_BIT] & ctla_q[CTLA_APPLY_BIT];
      start_gain = floor_on ? ctlb_q[CTLB_FLOOR_LSB +: GAIN_W] : GAIN_MIN;
      dwell_code = ctlb_q[CTLB_DWELL_LSB +: DWELL_CODE_W];
      reload = dwell_reload(dwell_code);
   end

   // register writes and read data; restart bit is not stored so it reads 0
   always_comb begin
      ctla_d = ctla_q;
      ctlb_d = ctlb_q;
      if (SOFT_RST) begin
         ctla_d = CTLA_RESET;
         ctlb_d = CTLB_RESET;
      end else if (REG_WR && REG_ADDR == ADDR_CTL_A) begin
         ctla_d = REG_WDATA & CTLA_MASK;
      end else if (REG_WR && REG_ADDR == ADDR_CTL_B) begin
         ctlb_d = REG_WDATA & CTLB_MASK;
      end
      unique case (REG_ADDR)
         ADDR_CTL_A: rdata_d = ctla_q;
         ADDR_CTL_B: rdata_d = ctlb_q;
         ADDR_STATUS: rdata_d = {gain_q[1], gain_q[0]};
         default: rdata_d = READ_ZERO;
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctla_q <= CTLA_RESET;
         ctlb_q <= CTLB_RESET;
         rdata_q <= READ_ZERO;
      end else begin
         ctla_q <= ctla_d;
         ctlb_q <= ctlb_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // per-port lock synchronisers and search engines
   // ---------------------------------------------------------------
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_sync
      lock_sync u_sync (
         .CLOCK(CLOCK),
         .RST(RST),
         .LOCK_ASYNC(CDR_LOCK[p]),
         .LOCK_SYNC(lock_s[p])
      );
   end

   // search step per port; the dwell is checked only when its count is spent
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         state_d[p] = state_q[p];
         gain_d[p] = gain_q[p];
         cnt_d[p] = cnt_q[p];
         if (restart_evt) begin
            state_d[p] = ST_SEARCH;
            gain_d[p] = start_gain;
            cnt_d[p] = reload;
         end else begin
            unique case (state_q[p])
               ST_SEARCH: begin
                  if (cnt_q[p] != '0) begin
                     cnt_d[p] = cnt_q[p] - 24'h00_0001;
                  end else if (lock_s[p]) begin
                     state_d[p] = ST_HOLD;
                  end else begin
                     gain_d[p] = next_gain(gain_q[p], start_gain);
                     cnt_d[p] = reload;
                  end
               end
               ST_HOLD: begin
                  if (!lock_s[p]) begin
                     state_d[p] = ST_SEARCH;
                     gain_d[p] = next_gain(gain_q[p], start_gain);
                     cnt_d[p] = reload;
                  end
               end
            endcase
         end
      end
   end

   // reset starts searching at once from the minimum gain
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            state_q[p] <= ST_SEARCH;
            gain_q[p] <= GAIN_MIN;
            cnt_q[p] <= dwell_reload(DWELL_CODE_W'(DWELL_DEFAULT_CODE));
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            state_q[p] <= state_d[p];
            gain_q[p] <= gain_d[p];
            cnt_q[p] <= cnt_d[p];
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign REG_RDATA = rdata_q;
   assign EQ_GAIN_P0 = gain_q[0];
   assign EQ_GAIN_P1 = gain_q[1];
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         EQ_HOLD[p] = (state_q[p] == ST_HOLD);
      end
   end

   // ---------------------------------------------------------------
   // assertions, port 0 stands for every port
   // ---------------------------------------------------------------
   a_hold_after_dwell: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q[0] == ST_SEARCH && cnt_q[0] == '0 && lock_s[0] && !restart_evt)
      |=> (state_q[0] == ST_HOLD))
      else $error("lock after dwell did not hold the gain");

   a_no_early_hold: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q[0] == ST_SEARCH && cnt_q[0] != '0 && !restart_evt)
      |=> (state_q[0] == ST_SEARCH && cnt_q[0] == $past(cnt_q[0]) - 24'h00_0001))
      else $error("search left dwell before the count was spent");

   a_hold_keeps_gain: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q[0] == ST_HOLD && lock_s[0] && !restart_evt)
      |=> ($stable(gain_q[0]) && state_q[0] == ST_HOLD))
      else $error("held gain changed while locked");

   a_loss_advances: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q[0] == ST_HOLD && !lock_s[0] && !restart_evt
       && gain_q[0] != GAIN_MAX && gain_q[0] >= start_gain)
      |=> (gain_q[0] == $past(gain_q[0]) + 4'h1 && state_q[0] == ST_SEARCH
           && cnt_q[0] == $past(reload)))
      else $error("lock loss did not advance the gain");

   a_restart_start: assert property (@(posedge CLOCK) disable iff (RST)
      restart_evt |=> (gain_q[0] == $past(start_gain) && state_q[0] == ST_SEARCH
                       && cnt_q[0] == $past(reload)))
      else $error("restart did not return to the start gain");

   a_floor_gate: assert property (@(posedge CLOCK) disable iff (RST)
      (restart_evt && !(ctla_q[CTLA_OVR_BIT] && ctla_q[CTLA_APPLY_BIT]) && !SOFT_RST)
      |=> gain_q[0] == GAIN_MIN)
      else $error("floor used without both enable bits");

   a_wrap_top: assert property (@(posedge CLOCK) disable iff (RST)
      (state_q[0] == ST_SEARCH && cnt_q[0] == '0 && !lock_s[0] && !restart_evt
       && gain_q[0] == GAIN_MAX)
      |=> gain_q[0] == $past(start_gain))
      else $error("no wrap to start after the top gain");

   a_status_gain: assert property (@(posedge CLOCK) disable iff (RST)
      (REG_ADDR == ADDR_STATUS) |=> (REG_RDATA[GAIN_W-1:0] == $past(gain_q[0])
                                     && REG_RDATA[STAT_P1_LSB +: GAIN_W] == $past(gain_q[1])))
      else $error("status does not show the current gain");

endmodule : eq_search_ctrl

// >>> tb/cdr_model.sv
// behavioural model of the analog equalizer and recovery lock, one per port
// assumes gains from the controller and signal and drop commands from the bench
`timescale 1ns/1ps
module cdr_model (
   input wire logic [3:0] GAIN_P0, // applied gain port 0
   input wire logic [3:0] GAIN_P1, // applied gain port 1
   input wire logic [7:0] TARGET, // opening gain, port 1 high nibble
   input wire logic [1:0] LOCK_EN, // signal present per port
   input wire logic [1:0] DROP, // forced loss of lock per port
   output logic [1:0] LOCK // raw lock level per port
);
   // one gain opens the eye; the delay keeps lock edges clear of the clock edge
   assign #7 LOCK[0] = LOCK_EN[0] && !DROP[0] && (GAIN_P0 == TARGET[3:0]);
   assign #7 LOCK[1] = LOCK_EN[1] && !DROP[1] && (GAIN_P1 == TARGET[7:4]);
endmodule : cdr_model

// >>> tb/eq_search_ctrl_test.sv
// self-checking bench for the equalizer gain search controller
// assumes the lock model beside it and a 40 MHz core clock
`timescale 1ns/1ps
module eq_search_ctrl_test;
   import eq_search_pkg::*;
   localparam int DW = 16; // shortened default dwell
   logic CLOCK, RST, SOFT_RST, REG_WR;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, TARGET;
   logic [1:0] CDR_LOCK, EQ_HOLD, LOCK_EN, DROP;
   logic [3:0] EQ_GAIN_P0, EQ_GAIN_P1;
   logic [7:0] exp_q[$];
   // a dwell of two cycles per gain: the top and the floor alternate in pairs
   logic [7:0] wrap_seq[6] = '{8'hEE, 8'hFF, 8'hFF, 8'hEE, 8'hEE, 8'hFF};
   int fail_count = 0;
   int checked = 0;
   int issued = 0;
   int taken = 0;
   logic cmp_now = 1'b0;

   eq_search_ctrl #(.DWELL_CYC(DW)) uut (.CLOCK(CLOCK), .RST(RST), .SOFT_RST(SOFT_RST),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
      .CDR_LOCK(CDR_LOCK), .EQ_GAIN_P0(EQ_GAIN_P0), .EQ_GAIN_P1(EQ_GAIN_P1), .EQ_HOLD(EQ_HOLD));
   cdr_model far (.GAIN_P0(EQ_GAIN_P0), .GAIN_P1(EQ_GAIN_P1), .TARGET(TARGET),
      .LOCK_EN(LOCK_EN), .DROP(DROP), .LOCK(CDR_LOCK));

   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic compare(input logic [7:0] got, input logic [7:0] e);
      checked++;
      if (got !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, e);
      end
   endtask : compare

   // strobe drops a full cycle before the next driver change, no same-step rewrite
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge CLOCK);
      REG_WR = 1'b0;
      @(negedge CLOCK);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      REG_ADDR = a;
      exp_q.push_back(e);
      issued++;
      @(negedge CLOCK);
   endtask : rd

   // read data lands at the edge after the address; judged at the next falling edge
   always @(posedge CLOCK) begin
      cmp_now <= (issued != taken);
      taken <= issued;
   end
   always @(negedge CLOCK) begin
      if (cmp_now) compare(REG_RDATA, exp_q.pop_front());
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      logic [7:0] r;
      logic [3:0] s;
      logic [7:0] nxt;
      int d;
      RST = 1'b1;
      SOFT_RST = 1'b0;
      REG_WR = 1'b0;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      TARGET = 8'h63;
      LOCK_EN = 2'b00;
      DROP = 2'b00;
      void'($urandom(32'h4cb89dc5));
      repeat (3) @(posedge CLOCK);
      @(negedge CLOCK);
      RST = 1'b0;
      // search starts alone; margin covers either reload edge
      rd(ADDR_STATUS, READ_ZERO);
      repeat (24) @(negedge CLOCK);
      rd(ADDR_STATUS, 8'h11);
      rd(ADDR_CTL_A, CTLA_RESET);
      rd(ADDR_CTL_B, CTLB_RESET);
      rd(8'h10, READ_ZERO);
      // random bytes, then writes to read-only and unmapped places
      repeat (4) begin
         r = 8'($urandom);
         wr(ADDR_CTL_B, r);
         rd(ADDR_CTL_B, r & CTLB_MASK);
         wr(ADDR_CTL_A, r);
         wr(ADDR_STATUS, 8'hFF);
         wr(8'h10, 8'hFF);
         rd(ADDR_CTL_A, r & CTLA_MASK);
      end
      // a restart uses the floor enables already stored, so set them first
      wr(ADDR_CTL_A, 8'h06);
      // each dwell code with a random floor: last cycle of the dwell, then the step
      for (int c = 0; c < 8; c++) begin
         s = 4'($urandom);
         d = (DW << c) >> 3;
         nxt = (s == GAIN_MAX) ? {s, s} : {s + 4'h1, s + 4'h1};
         wr(ADDR_CTL_B, {3'(c), 1'b0, s});
         wr(ADDR_CTL_A, 8'h07);
         rd(ADDR_STATUS, {s, s});
         repeat ((d > 3) ? d - 3 : 0) @(negedge CLOCK);
         rd(ADDR_STATUS, (d < 3) ? nxt : {s, s});
         rd(ADDR_STATUS, nxt);
      end
      // floor only with both enables, stored before the restart
      wr(ADDR_CTL_B, 8'h65);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTL_A, {5'h00, 2'(k), 1'b0});
         wr(ADDR_CTL_A, {5'h00, 2'(k), 1'b1});
         rd(ADDR_STATUS, (k == 3) ? 8'h55 : 8'h00);
      end
      // top setting fails and wraps to the floor
      wr(ADDR_CTL_B, 8'h0E);
      wr(ADDR_CTL_A, 8'h07);
      foreach (wrap_seq[i]) rd(ADDR_STATUS, wrap_seq[i]);
      // both ports find their own gain and hold it
      wr(ADDR_CTL_B, CTLB_RESET);
      LOCK_EN = 2'b11;
      wr(ADDR_CTL_A, 8'h01);
      rd(ADDR_STATUS, READ_ZERO);
      repeat (200) @(negedge CLOCK);
      rd(ADDR_STATUS, 8'h63);
      compare({6'h00, EQ_HOLD}, 8'h03);
      repeat (300) @(negedge CLOCK);
      rd(ADDR_STATUS, 8'h63);
      // port 0 loses lock: it steps on while port 1 stays
      DROP = 2'b01;
      repeat (5) @(negedge CLOCK);
      rd(ADDR_STATUS, 8'h64);
      compare({6'h00, EQ_HOLD}, 8'h02);
      DROP = 2'b00;
      repeat (400) @(negedge CLOCK);
      rd(ADDR_STATUS, 8'h63);
      // soft reset clears controls and restarts the search
      wr(ADDR_CTL_A, 8'h06);
      SOFT_RST = 1'b1;
      @(negedge CLOCK);
      SOFT_RST = 1'b0;
      rd(ADDR_CTL_A, CTLA_RESET);
      rd(ADDR_STATUS, READ_ZERO);
      // let the last read be judged before the verdict
      @(negedge CLOCK);
      give_verdict();
   end

   // run needs under 2000 cycles; a hang is cut well beyond that
   initial begin
      #(25 * 6000);
      fail_count++;
      give_verdict();
   end
endmodule : eq_search_ctrl_test
